//--- board_model.sv
// Board logic model that drives the trigger and alarm pins.
`timescale 1ns/10ps
module board_model (
  // Clock.
  input  wire logic clk_in,
  // Levels requested by the bench.
  input  wire logic trig_level_in,
  input  wire logic alarm_level_in,
  // Pins towards the device.
  output logic      trig_pin_out,
  output logic      alarm_pin_out
);
  // Pins change only on a clock edge, as real board logic would.
  // The pin is driven at all times, so no floating value is modelled.
  always_ff @(posedge clk_in) begin
    trig_pin_out  <= trig_level_in;
    alarm_pin_out <= alarm_level_in;
  end
endmodule

//--- cal_sequencer.sv
// Calibration phase sequencer producing the done and stopped flags.
`timescale 1ns/10ps
module cal_sequencer
  import cal_trig_pkg::*;
#(
  parameter int RESET_LEN = RESET_CYCLES,
  parameter int FG_LEN    = FG_CYCLES,
  parameter int PHASE_LEN = PHASE_CYCLES,
  parameter int CNT_W     = 8
) (
  // Clock and reset.
  input  wire logic      clk_in,
  input  wire logic      reset_in,
  // Configuration and status.
  input  wire cal_cfg_t  cfg_in,
  output cal_stat_t      stat_out
);

  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic             foreground_complete_flag_q;
  logic             phase_end;
  logic             cnt_end;

  ////////////////////////////////////////////////////////////////////////////
  // Phase end compare for the current state.
  always_comb begin
    cnt_end   = 1'b0;
    phase_end = (cnt_q == CNT_W'(PHASE_LEN - 1));
    case (state_q)
      ST_RESETV: cnt_end = (cnt_q == CNT_W'(RESET_LEN - 1));
      ST_FG:     cnt_end = (cnt_q == CNT_W'(FG_LEN - 1));
      default:   cnt_end = 1'b0;
    endcase
  end

  // Next state; a low enable overrides everything and holds the engine.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (cfg_in.cal_en) state_d = ST_RESETV;
      end
      ST_RESETV: begin
        if (cnt_end) begin
          if (cfg_in.fg_run) state_d = ST_FG;
          else if (cfg_in.bg_en) state_d = ST_BG;
          else state_d = ST_STOPPED;
        end
      end
      ST_FG: begin
        if (cnt_end) state_d = cfg_in.bg_en ? ST_BG : ST_STOPPED;
      end
      ST_BG: begin
        if (!cfg_in.bg_en || (cfg_in.stop_req && phase_end)) begin
          state_d = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (cfg_in.bg_en && !cfg_in.stop_req) state_d = ST_BG;
      end
      default: state_d = ST_HOLD;
    endcase
    if (!cfg_in.cal_en) state_d = ST_HOLD;
  end

  // State and phase counter; the counter wraps to mark background phases.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= ST_HOLD;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) cnt_q <= '0;
      else if (state_q == ST_BG && phase_end) cnt_q <= '0;
      else cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || state_d == ST_HOLD) foreground_complete_flag_q <= 1'b0;
    else if ((state_q == ST_RESETV || state_q == ST_FG) && cnt_end &&
             (state_d != ST_FG)) foreground_complete_flag_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status code
  always_comb begin
    case (state_q)
      ST_RESETV:  stat_out.code = CODE_RESET;
      ST_FG:      stat_out.code = CODE_FG;
      ST_BG:      stat_out.code = CODE_BG;
      ST_STOPPED: stat_out.code = CODE_STOPPED;
      default:    stat_out.code = CODE_HOLD;
    endcase
    stat_out.stopped = (state_q == ST_STOPPED);
    stat_out.foreground_complete_flag = foreground_complete_flag_q;
  end

endmodule

//--- cal_status_trigger.sv
// Calibration status, status pin routing and trigger source selection.
`timescale 1ns/10ps
module cal_status_trigger
  import cal_trig_pkg::*;
#(
  parameter int RESET_LEN = RESET_CYCLES,
  parameter int FG_LEN    = FG_CYCLES,
  parameter int PHASE_LEN = PHASE_CYCLES
) (
  // Clock and reset.
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // Avalon-MM slave.
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              read_in,
  input  wire logic              write_in,
  input  wire logic [DATA_W-1:0] writedata_in,
  input  wire logic [3:0]        byteenable_in,
  output logic [DATA_W-1:0]      readdata_out,
  output logic                   waitrequest_out,
  // Board pins.
  input  wire logic              calibration_trigger_input_pin_in,
  input  wire logic              alarm_in,
  output logic                   calibration_status_output_pin_out,
  output logic                   calibration_trigger_out,
  output logic                   core_wake_out,
  // Interrupt.
  output logic                   irq_out
);

  logic [7:0]        control_q;
  logic [7:0]        config_q;
  logic [7:0]        stop_q;
  logic [7:0]        pin_cfg_q;
  logic [7:0]        soft_trig_q;
  logic [7:0]        low_power_q;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_status_d;
  logic [IRQ_W-1:0]  irq_enable_q;
  logic [IRQ_W-1:0]  irq_clear;
  logic [IRQ_W-1:0]  irq_event;
  logic              fg_prev_q;
  logic              stopped_prev_q;
  logic              alarm_prev_q;
  logic              waitrequest_q;
  logic [DATA_W-1:0] readdata_q;
  logic              status_pin_q;
  logic              trigger_q;
  logic              wake_q;
  logic              irq_q;
  logic [IDX_W-1:0]  word_idx;
  logic              wr_en;
  logic [7:0]        wr_byte;
  logic [7:0]        rd_byte;
  logic              sel_trigger;
  pin_sel_t          pin_sel;
  cal_cfg_t          cfg;
  cal_stat_t         stat;

  assign word_idx = address_in[ADDR_W-1:2];
  assign wr_byte  = writedata_in[7:0];
  assign wr_en    = write_in && !waitrequest_q && byteenable_in[0];
  assign pin_sel  = pin_sel_t'(pin_cfg_q[POS_PIN_SEL +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // One wait cycle per access: the first cycle of a request raises the data,
  // the second drops waitrequest. It costs a cycle but keeps readdata a flop.
  always_ff @(posedge clk_in) begin
    if (reset_in) waitrequest_q <= 1'b1;
    else if ((read_in || write_in) && waitrequest_q) waitrequest_q <= 1'b0;
    else waitrequest_q <= 1'b1;
  end

  // Read decode; unmapped and write-only words read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (word_idx == IDX_CONTROL) rd_byte = control_q;
    else if (word_idx == IDX_CONFIG) rd_byte = config_q;
    else if (word_idx == IDX_STOP) rd_byte = stop_q;
    else if (word_idx == IDX_STATUS) rd_byte = {3'h0, stat};
    else if (word_idx == IDX_PIN_CFG) rd_byte = pin_cfg_q;
    else if (word_idx == IDX_SOFT_TRIG) rd_byte = soft_trig_q;
    else if (word_idx == IDX_LOW_POWER) rd_byte = low_power_q;
    else if (word_idx == IDX_IRQ_STATUS) rd_byte = {5'h00, irq_status_q};
    else if (word_idx == IDX_IRQ_ENABLE) rd_byte = {5'h00, irq_enable_q};
  end

  // Read data captured while waitrequest is still high.
  always_ff @(posedge clk_in) begin
    if (reset_in) readdata_q <= '0;
    else if (read_in && waitrequest_q) readdata_q <= {24'h000000, rd_byte};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      control_q    <= RST_CONTROL;
      config_q     <= RST_CONFIG;
      stop_q       <= RST_STOP;
      pin_cfg_q    <= RST_PIN_CFG;
      soft_trig_q  <= RST_SOFT_TRIG;
      low_power_q  <= RST_LOW_POWER;
      irq_enable_q <= '0;
    end else if (wr_en) begin
      if (word_idx == IDX_CONTROL) control_q <= wr_byte;
      else if (word_idx == IDX_CONFIG) config_q <= wr_byte;
      else if (word_idx == IDX_STOP) stop_q <= wr_byte;
      else if (word_idx == IDX_PIN_CFG) pin_cfg_q <= wr_byte;
      else if (word_idx == IDX_SOFT_TRIG) soft_trig_q <= wr_byte;
      else if (word_idx == IDX_LOW_POWER) low_power_q <= wr_byte;
      else if (word_idx == IDX_IRQ_ENABLE) begin
        irq_enable_q <= wr_byte[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration handed to the sequencer.
  assign cfg.cal_en   = control_q[POS_CAL_EN];
  assign cfg.fg_run   = config_q[POS_FG_RUN];
  assign cfg.bg_en    = config_q[POS_BG_EN];
  assign cfg.stop_req = stop_q[POS_STOP_REQ];

  cal_sequencer #(
    .RESET_LEN (RESET_LEN),
    .FG_LEN    (FG_LEN),
    .PHASE_LEN (PHASE_LEN),
    .CNT_W     (8)
  ) u_seq (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .cfg_in   (cfg),
    .stat_out (stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source; the unused source is not looked at at all.
  always_comb begin
    sel_trigger = soft_trig_q[POS_SOFT_TRIG];
    if (pin_cfg_q[POS_TRIG_SEL]) sel_trigger = calibration_trigger_input_pin_in;
  end

  // Registered trigger and wake request.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      trigger_q <= 1'b1;
      wake_q    <= 1'b0;
    end else begin
      trigger_q <= sel_trigger;
      wake_q    <= low_power_q[POS_LP_EN] && low_power_q[POS_SLEEP_UNTIL_TRIGGER_MODE] &&
                   cfg.cal_en && cfg.bg_en && !sel_trigger;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) status_pin_q <= 1'b0;
    else begin
      case (pin_sel)
        PIN_FG:      status_pin_q <= stat.foreground_complete_flag;
        PIN_STOPPED: status_pin_q <= stat.stopped;
        PIN_ALARM:   status_pin_q <= alarm_in;
        default:     status_pin_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rising edges of done, stopped and alarm are interrupt events.
  assign irq_event[IRQ_FG]      = stat.foreground_complete_flag && !fg_prev_q;
  assign irq_event[IRQ_STOPPED] = stat.stopped && !stopped_prev_q;
  assign irq_event[IRQ_ALARM]   = alarm_in && !alarm_prev_q;
  assign irq_clear = (wr_en && word_idx == IDX_IRQ_CLEAR) ?
                     wr_byte[IRQ_W-1:0] : '0;
  // An event in the cycle of its clear survives: set wins.
  assign irq_status_d = (irq_status_q & ~irq_clear) | irq_event;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fg_prev_q      <= 1'b0;
      stopped_prev_q <= 1'b0;
      alarm_prev_q   <= 1'b0;
      irq_status_q   <= '0;
      irq_q          <= 1'b0;
    end else begin
      fg_prev_q      <= stat.foreground_complete_flag;
      stopped_prev_q <= stat.stopped;
      alarm_prev_q   <= alarm_in;
      irq_status_q   <= irq_status_d;
      irq_q          <= |(irq_status_q & irq_enable_q);
    end
  end

  assign readdata_out                      = readdata_q;
  assign waitrequest_out                   = waitrequest_q;
  assign calibration_status_output_pin_out = status_pin_q;
  assign calibration_trigger_out           = trigger_q;
  assign core_wake_out                     = wake_q;
  assign irq_out                           = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_bg_running;
    stat.code == CODE_BG;
  endsequence

  sequence s_halted;
    stat.code == CODE_STOPPED ##1 stat.stopped;
  endsequence

  // A halt must have been asked for, by a stop request or background off.
  a_stop_flag_set: assert property (
    s_bg_running ##1 (stat.code == CODE_STOPPED) |->
      stat.stopped && ($past(cfg.stop_req) || !$past(cfg.bg_en)))
    else $error("halt without request or stopped flag low");

  a_resume_clears: assert property (
    s_halted ##1 (stat.code == CODE_BG) |-> !stat.stopped)
    else $error("stopped flag high while running");

  a_bg_off_stop: assert property (
    cfg.cal_en && !$past(cfg.bg_en) && $rose(stat.foreground_complete_flag) |-> stat.stopped)
    else $error("stopped flag missing with background off");

  a_foreground_complete_flag_src: assert property (
    $rose(stat.foreground_complete_flag) |->
      ($past(stat.code) == CODE_FG || $past(stat.code) == CODE_RESET))
    else $error("done flag rose outside foreground");

  a_pin_route: assert property (
    (pin_sel == PIN_STOPPED) ##1 (pin_sel == PIN_STOPPED)
      |-> status_pin_q == $past(stat.stopped))
    else $error("status pin does not follow stopped flag");

  a_pin_low: assert property (
    (pin_sel == PIN_LOW) |=> !status_pin_q)
    else $error("status pin high in low mode");

  a_soft_source: assert property (
    !pin_cfg_q[POS_TRIG_SEL] |=> trigger_q == $past(soft_trig_q[0]))
    else $error("trigger not from software bit");

  a_pin_source: assert property (
    pin_cfg_q[POS_TRIG_SEL] |=>
      trigger_q == $past(calibration_trigger_input_pin_in))
    else $error("trigger not from pin");

  a_soft_reset: assert property (
    $fell(reset_in) |-> soft_trig_q[POS_SOFT_TRIG] && stat.code == CODE_HOLD)
    else $error("software trigger or code wrong after reset");

  a_core_wake: assert property (
    low_power_q[POS_LP_EN] && low_power_q[POS_SLEEP_UNTIL_TRIGGER_MODE] && cfg.cal_en &&
    cfg.bg_en && !sel_trigger |=> core_wake_out)
    else $error("core not woken by low trigger");

  a_fg_skip: assert property (
    (stat.code == CODE_RESET) ##1 (stat.code == CODE_FG) |-> $past(cfg.fg_run))
    else $error("foreground ran while skip selected");

  a_hold_reset: assert property (
    !cfg.cal_en |=> stat.code == CODE_HOLD && !stat.foreground_complete_flag && !stat.stopped)
    else $error("calibration not held with enable low");

  a_pin_done: assert property (
    (pin_sel == PIN_FG) ##1 (pin_sel == PIN_FG)
      |-> status_pin_q == $past(stat.foreground_complete_flag))
    else $error("status pin does not follow done flag");

  a_pin_alarm: assert property (
    (pin_sel == PIN_ALARM) ##1 (pin_sel == PIN_ALARM)
      |-> status_pin_q == $past(alarm_in))
    else $error("status pin does not follow alarm");

  // Masters may count on one wait cycle; a longer stall would slow polling.
  a_wait_single: assert property ( // Bus wait
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("waitrequest held for more than one cycle");

  a_irq_set_wins: assert property ( // Set wins
    irq_event[IRQ_ALARM] |=> irq_status_q[IRQ_ALARM])
    else $error("alarm event lost in status");

  a_irq_level: assert property ( // Interrupt
    (|(irq_status_q & irq_enable_q)) |=> irq_out)
    else $error("interrupt low with enabled status set");

  a_irq_quiet: assert property ( // Interrupt
    !(|(irq_status_q & irq_enable_q)) |=> !irq_out)
    else $error("interrupt high with no enabled status");

endmodule

//--- cal_trig_pkg.sv
// Shared constants, types and register map of the calibration status block.
package cal_trig_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry: each register takes one aligned 32-bit word.
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int IDX_W  = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CONTROL    = 8'h61;
  localparam logic [IDX_W-1:0] IDX_CONFIG     = 8'h62;
  localparam logic [IDX_W-1:0] IDX_STOP       = 8'h69;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 8'h6a;
  localparam logic [IDX_W-1:0] IDX_PIN_CFG    = 8'h6b;
  localparam logic [IDX_W-1:0] IDX_SOFT_TRIG  = 8'h6c;
  localparam logic [IDX_W-1:0] IDX_LOW_POWER  = 8'h6e;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h74;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 8'h75;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'h76;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int POS_CAL_EN    = 0;
  localparam int POS_FG_RUN    = 0;
  localparam int POS_BG_EN     = 1;
  localparam int POS_STOP_REQ  = 0;
  localparam int POS_TRIG_SEL  = 0;
  localparam int POS_PIN_SEL   = 1;
  localparam int POS_SOFT_TRIG = 0;
  localparam int POS_LP_EN     = 0;
  localparam int POS_SLEEP_UNTIL_TRIGGER_MODE   = 1;

  // Reset values.
  localparam logic [7:0] RST_CONTROL   = 8'h01;
  localparam logic [7:0] RST_CONFIG    = 8'h01;
  localparam logic [7:0] RST_STOP      = 8'h00;
  localparam logic [7:0] RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LOW_POWER = 8'h88;

  // Interrupt bits.
  localparam int IRQ_W       = 3;
  localparam int IRQ_FG      = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_ALARM   = 2;

  // Sequencer timing counts in clock cycles.
  localparam int RESET_CYCLES = 4;
  localparam int FG_CYCLES    = 64;
  localparam int PHASE_CYCLES = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Status pin routing choices.
  typedef enum logic [1:0] {
    PIN_FG      = 2'h0,
    PIN_STOPPED = 2'h1,
    PIN_ALARM   = 2'h2,
    PIN_LOW     = 2'h3
  } pin_sel_t;

  // Status codes reported to software.
  typedef enum logic [2:0] {
    CODE_HOLD    = 3'h0,
    CODE_RESET   = 3'h1,
    CODE_FG      = 3'h2,
    CODE_BG      = 3'h3,
    CODE_STOPPED = 3'h4
  } status_code_t;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_HOLD    = 5'h01,
    ST_RESETV  = 5'h02,
    ST_FG      = 5'h04,
    ST_BG      = 5'h08,
    ST_STOPPED = 5'h10
  } seq_state_t;

  typedef struct packed {
    logic cal_en;
    logic fg_run;
    logic bg_en;
    logic stop_req;
  } cal_cfg_t;

  typedef struct packed {
    status_code_t code;
    logic         stopped;
    logic         foreground_complete_flag;
  } cal_stat_t;

endpackage

//--- tb_top.sv
// Self-checking testbench of the calibration status and trigger block.
`timescale 1ns/10ps
module tb_top;
  import cal_trig_pkg::*;
  logic              clk_in, reset_in, read_in, write_in;
  logic [ADDR_W-1:0] address_in;
  logic [DATA_W-1:0] writedata_in, readdata_out;
  logic [3:0]        be;
  logic              waitrequest_out, trig_lvl, alarm_lvl, trig_pin, alarm_pin;
  logic              stat_pin, trig_out, wake, irq;
  int                fails, num_checks, cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Small counts keep the background phase short; foreground stays long.
  cal_status_trigger #(.RESET_LEN(2), .FG_LEN(64), .PHASE_LEN(4))
    cal_status_trigger_inst (
    .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(be), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .calibration_trigger_input_pin_in(trig_pin), .alarm_in(alarm_pin),
    .calibration_status_output_pin_out(stat_pin),
    .calibration_trigger_out(trig_out), .core_wake_out(wake),
    .irq_out(irq));
  board_model board_model_inst (.clk_in(clk_in), .trig_level_in(trig_lvl),
    .alarm_level_in(alarm_lvl), .trig_pin_out(trig_pin),
    .alarm_pin_out(alarm_pin));

  // Clock of 40 ns period.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // A hang is cut short after a generous cycle ceiling.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer; waitrequest is looked at mid-cycle, where it has
  // settled, and the request is released at the edge that accepts it.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    address_in   <= {idx, 2'b00};
    write_in     <= wr;
    read_in      <= ~wr;
    writedata_in <= {24'h0, wd};
    do begin
      @(negedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 8'h00, 8'h01);
    @(posedge clk_in);
    rd = readdata_out[7:0];
    read_in  <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, idx, d, v);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx,
                     input logic [7:0] e);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(nm, e, v);
  endtask

  // Reads status until it matches or the read budget runs out.
  task automatic poll(input logic [7:0] e, input int lim);
    logic [7:0] v;
    int k;
    k = 0;
    do begin
      bus(1'b0, IDX_STATUS, 8'h00, v);
      k++;
    end while (v !== e && k < lim);
    chk("status", e, v);
  endtask

  // Lets pin changes pass the board model and the output registers.
  task automatic settle();
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rdc("pin_cfg", IDX_PIN_CFG, 8'h00);
    rdc("soft_trig", IDX_SOFT_TRIG, 8'h01);
    rdc("low_power", IDX_LOW_POWER, 8'h88);
    rdc("control", IDX_CONTROL, 8'h01);
    rdc("config", IDX_CONFIG, 8'h01);
    wr(8'h10, 8'h5a);
    rdc("unmapped", 8'h10, 8'h00);
    be <= 4'he;
    wr(IDX_SOFT_TRIG, 8'h00);
    be <= 4'hf;
    rdc("masked write", IDX_SOFT_TRIG, 8'h01);
  endtask

  task automatic t_foreground_irq();
    poll(8'h13, 60);
    rdc("irq_status", IDX_IRQ_STATUS, 8'h03);
    wr(IDX_IRQ_ENABLE, 8'h01);
    settle();
    chk("irq_out", 8'h01, {7'h0, irq});
    wr(IDX_IRQ_CLEAR, 8'h03);
    rdc("irq cleared", IDX_IRQ_STATUS, 8'h00);
    settle();
    chk("irq_out", 8'h00, {7'h0, irq});
  endtask

  task automatic t_skip();
    wr(IDX_CONFIG, 8'h00);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CONTROL, 8'h01);
    poll(8'h13, 3);
  endtask

  task automatic t_background();
    wr(IDX_CONFIG, 8'h03);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CONTROL, 8'h01);
    poll(8'h0d, 60);
    wr(IDX_STOP, 8'h01);
    poll(8'h13, 10);
    wr(IDX_STOP, 8'h00);
    poll(8'h0d, 3);
    wr(IDX_CONTROL, 8'h00);
    poll(8'h00, 3);
    wr(IDX_CONTROL, 8'h01);
    poll(8'h0d, 60);
  endtask

  // Background runs: done is 1 and stopped is 0 while routes are tried.
  task automatic t_pin_route();
    logic [7:0] e;
    wr(IDX_IRQ_ENABLE, 8'h00);
    wr(IDX_IRQ_CLEAR, 8'h07);
    for (int a = 1; a >= 0; a--) begin
      alarm_lvl <= a[0];
      for (int s = 0; s < 4; s++) begin
        wr(IDX_PIN_CFG, {5'h0, s[1:0], 1'b0});
        settle();
        e = (s == 0) ? 8'h01 : (s == 2) ? {7'h0, a[0]} : 8'h00;
        chk("status pin", e, {7'h0, stat_pin});
      end
    end
    alarm_lvl <= 1'b1;
    settle();
    rdc("alarm irq", IDX_IRQ_STATUS, 8'h04);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(IDX_IRQ_ENABLE, 8'h04);
    settle();
    chk("irq_out", 8'h01, {7'h0, irq});
    wr(IDX_IRQ_CLEAR, 8'h04);
    settle();
    chk("irq_out", 8'h00, {7'h0, irq});
  endtask

  // Each row: source select, software bit, pin level, expected trigger.
  task automatic t_trigger();
    logic [3:0] row [4];
    row = '{4'b0010, 4'b0101, 4'b1100, 4'b1011};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PIN_CFG, {7'h0, row[i][3]});
      wr(IDX_SOFT_TRIG, {7'h0, row[i][2]});
      trig_lvl <= row[i][1];
      settle();
      chk("trigger", {7'h0, row[i][0]}, {7'h0, trig_out});
    end
    wr(IDX_PIN_CFG, 8'h00);
    wr(IDX_LOW_POWER, 8'h8b);
    wr(IDX_SOFT_TRIG, 8'h00);
    settle();
    chk("core wake", 8'h01, {7'h0, wake});
    wr(IDX_SOFT_TRIG, 8'h01);
    settle();
    chk("core wake", 8'h00, {7'h0, wake});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    reset_in = 1'b1;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = '0;
    writedata_in = '0;
    be = 4'hf;
    trig_lvl = 1'b0;
    alarm_lvl = 1'b0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_values();
    t_foreground_irq();
    t_skip();
    t_background();
    t_pin_route();
    t_trigger();
    complete_run();
  end
endmodule
